// ===== include/ioxr_pkg.sv
package ioxr_pkg;

    // bus address: fixed upper pattern then three strap bits
    localparam logic [3:0] ADDR_PREFIX   = 4'h4;
    localparam logic [6:0] GENERAL_CALL  = 7'h00;

    // register pointer codes
    localparam logic [2:0] REG_LEVEL_LO  = 3'h0;
    localparam logic [2:0] REG_LEVEL_HI  = 3'h1;
    localparam logic [2:0] REG_DRIVE_LO  = 3'h2;
    localparam logic [2:0] REG_DRIVE_HI  = 3'h3;
    localparam logic [2:0] REG_INVERT_LO = 3'h4;
    localparam logic [2:0] REG_INVERT_HI = 3'h5;
    localparam logic [2:0] REG_DIR_LO    = 3'h6;
    localparam logic [2:0] REG_DIR_HI    = 3'h7;

    // reset values
    localparam logic [7:0] RST_DRIVE     = 8'hff;
    localparam logic [7:0] RST_INVERT    = 8'h00;
    localparam logic [7:0] RST_DIR       = 8'hff;
    localparam logic [2:0] RST_POINTER   = 3'h0;

    // framing
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam int         SYNC_STAGES   = 2;

    typedef enum logic [2:0] {
        IOXR_IDLE,
        IOXR_ADDR,
        IOXR_ADDR_ACK,
        IOXR_CMD,
        IOXR_WDATA,
        IOXR_WACK,
        IOXR_RDATA,
        IOXR_RACK
    } ioxr_phase_e;

    // one set of synchronised line samples
    typedef struct packed {
        logic        scl;
        logic        sda;
        logic [15:0] pins;
    } ioxr_lines_s;

    // register file: index 0 is the low bank
    typedef struct packed {
        logic [1:0][7:0] drive;
        logic [1:0][7:0] invert;
        logic [1:0][7:0] dir;
    } ioxr_regs_s;

endpackage : ioxr_pkg

// ===== rtl/ioxr_top.sv
`timescale 1ns/1ps
// Functional notes
// - start resets bit and byte framing
// - stop returns device to idle
// - address MSB first; ignore general call
// - matched address acknowledged on ninth clock
// - data changes with clock high mean start/stop
// - eight bits then released acknowledge bit
// - acknowledge every received byte while writing
// - master nack ends read; release data
// - address is fixed prefix plus straps
// - last address bit: 1 read, 0 write
// - first write byte stores register pointer
// - pointer persists across transactions
// - input registers report snapshotted pin levels
// - drive registers drive output pins only
// - invert bit set flips reported input
// - direction bit 1 means input, high-z
// - write data alternates within register pair
// - restart keeps currently accessed register
// - read data alternates within register pair
// - pins captured at acknowledge rising edge
// - change flag cleared at read ack edge
// - change flag tracked per eight-pin bank
module ioxr_top (
    // clock and reset
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_n,
    // serial bus, data line split into in/out/enable
    input  wire logic        i_scl,
    input  wire logic        i_sda,
    output logic             o_sda,
    output logic             o_sda_oe,
    // address straps
    input  wire logic        i_addr_strap_bit0,
    input  wire logic        i_addr_strap_bit1,
    input  wire logic        i_addr_strap_bit2,
    // port pins
    input  wire logic [7:0]  i_pins_low_bank,
    input  wire logic [7:0]  i_pins_high_bank,
    output logic      [7:0]  o_pins_low_bank,
    output logic      [7:0]  o_pins_high_bank,
    output logic      [7:0]  o_pins_low_bank_oe,
    output logic      [7:0]  o_pins_high_bank_oe,
    // change-detect flag per bank, active high
    output logic      [1:0]  o_change
);

    typedef struct packed {
        ioxr_pkg::ioxr_lines_s sync1;
        ioxr_pkg::ioxr_lines_s sync2;
        logic                  scl_d;
        logic                  sda_d;
        logic [2:0]            straps;
        ioxr_pkg::ioxr_phase_e phase;
        logic [3:0]            bit_cnt;
        logic [7:0]            shift;
        logic                  sda_out;
        logic                  sda_oe;
        logic                  rw;
        logic                  first_byte;
        logic [2:0]            pointer;
        ioxr_pkg::ioxr_regs_s  regs;
        logic [1:0][7:0]       snap;
        logic [1:0]            change;
        logic [7:0]            pins_lo;
        logic [7:0]            pins_hi;
        logic [7:0]            oe_lo;
        logic [7:0]            oe_hi;
    } ioxr_state_s;

    ioxr_state_s state_reg;
    ioxr_state_s state_next;

    logic            scl_rise;
    logic            scl_fall;
    logic            start_seen;
    logic            stop_seen;
    logic [6:0]      own_addr;
    logic [1:0][7:0] level;
    logic [1:0][7:0] reported;
    logic [2:0]      partner;
    logic            bank;
    logic [7:0]      rd_byte;

    // edges taken from the second stage only, never the first
    assign scl_rise   = state_reg.sync2.scl & ~state_reg.scl_d;
    assign scl_fall   = ~state_reg.sync2.scl & state_reg.scl_d;
    // data edge with clock held high is a bus condition
    assign start_seen = state_reg.sync2.scl & state_reg.scl_d &
                        state_reg.sda_d & ~state_reg.sync2.sda;
    assign stop_seen  = state_reg.sync2.scl & state_reg.scl_d &
                        ~state_reg.sda_d & state_reg.sync2.sda;
    // fixed prefix plus straps latched at start
    assign own_addr   = {ioxr_pkg::ADDR_PREFIX, state_reg.straps};
    assign level[0]   = state_reg.sync2.pins[7:0];
    assign level[1]   = state_reg.sync2.pins[15:8];
    // other register of the current pair
    assign partner    = {state_reg.pointer[2:1], ~state_reg.pointer[0]};
    // bank named by the pointer, kept short for the decode below
    assign bank       = state_reg.pointer[0];

    // reported levels: snapshot with inversion applied
    always_comb begin
        reported[0] = state_reg.snap[0] ^ state_reg.regs.invert[0];
        reported[1] = state_reg.snap[1] ^ state_reg.regs.invert[1];
    end

    // read mux over the eight registers; drive reads the latch
    always_comb begin
        case (state_reg.pointer)
            ioxr_pkg::REG_LEVEL_LO:  rd_byte = reported[0];
            ioxr_pkg::REG_LEVEL_HI:  rd_byte = reported[1];
            ioxr_pkg::REG_DRIVE_LO:  rd_byte = state_reg.regs.drive[0];
            ioxr_pkg::REG_DRIVE_HI:  rd_byte = state_reg.regs.drive[1];
            ioxr_pkg::REG_INVERT_LO: rd_byte = state_reg.regs.invert[0];
            ioxr_pkg::REG_INVERT_HI: rd_byte = state_reg.regs.invert[1];
            ioxr_pkg::REG_DIR_LO:    rd_byte = state_reg.regs.dir[0];
            ioxr_pkg::REG_DIR_HI:    rd_byte = state_reg.regs.dir[1];
            default:                 rd_byte = 8'h00;
        endcase
    end

    // whole next-state computation; the synchronisers and state register cost three clocks,
    // so each serial clock phase must last at least four reference clocks
    always_comb begin
        state_next = state_reg;
        // two-flop synchronisers on the bus lines and port pins; straps are not synchronised
        state_next.sync1.scl  = i_scl;
        state_next.sync1.sda  = i_sda;
        state_next.sync1.pins = {i_pins_high_bank, i_pins_low_bank};
        state_next.sync2      = state_reg.sync1;
        state_next.scl_d      = state_reg.sync2.scl;
        state_next.sda_d      = state_reg.sync2.sda;

        // change detect on input-mode pins; flag recomputed from the compare every clock
        // a pin turned from output to input flags at once if it differs
        for (int b = 0; b < 2; b++) begin
            if (((level[b] ^ state_reg.snap[b]) &
                 state_reg.regs.dir[b]) != 8'h00) begin
                state_next.change[b] = 1'b1;
            end else begin
                state_next.change[b] = 1'b0;
            end
        end

        if (start_seen) begin
            // start or repeated start: reframe
            state_next.phase   = ioxr_pkg::IOXR_ADDR;
            state_next.bit_cnt = 4'h0;
            state_next.sda_oe  = 1'b0;
            // straps are sampled again at every start, repeated starts included
            state_next.straps  = {i_addr_strap_bit2, i_addr_strap_bit1,
                                  i_addr_strap_bit0};
            // pointer already tracks the register in use
        end else if (stop_seen) begin
            // the pointer is left as it stands for the next frame
            state_next.phase  = ioxr_pkg::IOXR_IDLE;
            state_next.sda_oe = 1'b0;
        end else begin
            case (state_reg.phase)
                ioxr_pkg::IOXR_IDLE: begin
                    // bits between frames or for other devices are ignored
                    state_next.sda_oe = 1'b0;
                end
                ioxr_pkg::IOXR_ADDR, ioxr_pkg::IOXR_CMD,
                ioxr_pkg::IOXR_WDATA: begin
                    // shift in MSB first
                    if (scl_rise) begin
                        state_next.shift   = {state_reg.shift[6:0],
                                              state_reg.sync2.sda};
                        state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
                    end
                    if (scl_fall &&
                        state_reg.bit_cnt == ioxr_pkg::BITS_PER_BYTE) begin
                        state_next.bit_cnt = 4'h0;
                        if (state_reg.phase == ioxr_pkg::IOXR_ADDR) begin
                            // general call and foreign address: no ack
                            if (state_reg.shift[7:1] == own_addr &&
                                state_reg.shift[7:1] !=
                                ioxr_pkg::GENERAL_CALL) begin
                                state_next.phase   = ioxr_pkg::IOXR_ADDR_ACK;
                                state_next.rw      = state_reg.shift[0];
                                state_next.sda_out = 1'b0;
                                state_next.sda_oe  = 1'b1;
                            end else begin
                                state_next.phase = ioxr_pkg::IOXR_IDLE;
                            end
                        end else begin
                            if (state_reg.phase == ioxr_pkg::IOXR_CMD) begin
                                // command byte: low bits are pointer
                                state_next.pointer    = state_reg.shift[2:0];
                                state_next.first_byte = 1'b1;
                            end else begin
                                // write byte; input regs discard
                                case (state_reg.pointer[2:1])
                                    2'h1: begin
                                        state_next.regs.drive[bank] =
                                            state_reg.shift;
                                    end
                                    2'h2: begin
                                        state_next.regs.invert[bank] =
                                            state_reg.shift;
                                    end
                                    2'h3: begin
                                        state_next.regs.dir[bank] =
                                            state_reg.shift;
                                    end
                                    default: ;
                                endcase
                            end
                            state_next.phase   = ioxr_pkg::IOXR_WACK;
                            state_next.sda_out = 1'b0;
                            state_next.sda_oe  = 1'b1;
                        end
                    end
                end
                ioxr_pkg::IOXR_ADDR_ACK: begin
                    // capture the input bank about to go out
                    if (scl_rise && state_reg.rw &&
                        state_reg.pointer[2:1] == 2'h0) begin
                        state_next.snap[bank] = level[bank];
                    end
                    if (scl_fall) begin
                        if (state_reg.rw) begin
                            state_next.phase   = ioxr_pkg::IOXR_RDATA;
                            state_next.shift   = rd_byte;
                            state_next.sda_out = rd_byte[7];
                            state_next.sda_oe  = 1'b1;
                            state_next.bit_cnt = 4'h1;
                        end else begin
                            state_next.phase  = ioxr_pkg::IOXR_CMD;
                            state_next.sda_oe = 1'b0;
                        end
                    end
                end
                ioxr_pkg::IOXR_WACK: begin
                    if (scl_fall) begin
                        state_next.sda_oe = 1'b0;
                        state_next.phase  = ioxr_pkg::IOXR_WDATA;
                        // advance only after a data byte
                        // the command byte itself leaves the pointer alone
                        if (state_reg.first_byte) begin
                            state_next.first_byte = 1'b0;
                        end else begin
                            state_next.pointer = partner;
                        end
                    end
                end
                ioxr_pkg::IOXR_RDATA: begin
                    if (scl_fall) begin
                        // next bit set just after the fall: a full low phase
                        if (state_reg.bit_cnt == ioxr_pkg::BITS_PER_BYTE) begin
                            // release for master's ack
                            state_next.sda_oe  = 1'b0;
                            state_next.phase   = ioxr_pkg::IOXR_RACK;
                            state_next.bit_cnt = 4'h0;
                        end else begin
                            state_next.shift   = {state_reg.shift[6:0], 1'b0};
                            state_next.sda_out = state_reg.shift[6];
                            state_next.bit_cnt = state_reg.bit_cnt + 4'h1;
                        end
                    end
                end
                ioxr_pkg::IOXR_RACK: begin
                    if (scl_rise) begin
                        if (state_reg.pointer[2:1] == 2'h0) begin
                            // the bank just read is refreshed; after a nack the
                            // other bank keeps its flag
                            state_next.snap[bank] = level[bank];
                            // an ack asks for the other bank next
                            if (!state_reg.sync2.sda) begin
                                state_next.snap[~bank] = level[~bank];
                            end
                        end
                        state_next.pointer = partner;
                        if (state_reg.sync2.sda) begin
                            state_next.phase = ioxr_pkg::IOXR_IDLE;
                        end
                    end
                    if (scl_fall) begin
                        state_next.phase   = ioxr_pkg::IOXR_RDATA;
                        state_next.shift   = rd_byte;
                        state_next.sda_out = rd_byte[7];
                        state_next.sda_oe  = 1'b1;
                        state_next.bit_cnt = 4'h1;
                    end
                end
                default: begin
                    state_next.phase = ioxr_pkg::IOXR_IDLE;
                end
            endcase
        end

        // pin drivers: direction 1 is input, driver off
        state_next.pins_lo = state_next.regs.drive[0];
        state_next.pins_hi = state_next.regs.drive[1];
        state_next.oe_lo   = ~state_next.regs.dir[0];
        state_next.oe_hi   = ~state_next.regs.dir[1];
    end

    // single state register
    always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg             <= '0;
            state_reg.sync1.scl   <= 1'b1;
            state_reg.sync1.sda   <= 1'b1;
            state_reg.sync2.scl   <= 1'b1;
            state_reg.sync2.sda   <= 1'b1;
            state_reg.scl_d       <= 1'b1;
            state_reg.sda_d       <= 1'b1;
            state_reg.sda_out     <= 1'b1;
            state_reg.phase       <= ioxr_pkg::IOXR_IDLE;
            state_reg.pointer     <= ioxr_pkg::RST_POINTER;
            state_reg.regs.drive  <= {ioxr_pkg::RST_DRIVE,
                                      ioxr_pkg::RST_DRIVE};
            state_reg.regs.invert <= {ioxr_pkg::RST_INVERT,
                                      ioxr_pkg::RST_INVERT};
            state_reg.regs.dir    <= {ioxr_pkg::RST_DIR, ioxr_pkg::RST_DIR};
            state_reg.pins_lo     <= ioxr_pkg::RST_DRIVE;
            state_reg.pins_hi     <= ioxr_pkg::RST_DRIVE;
            state_reg.oe_lo       <= 8'h00;
            state_reg.oe_hi       <= 8'h00;
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs straight from flops; change flags are levels that drop
    // once that bank's input pins match its snapshot again
    assign o_sda               = state_reg.sda_out;
    assign o_sda_oe            = state_reg.sda_oe;
    assign o_pins_low_bank     = state_reg.pins_lo;
    assign o_pins_high_bank    = state_reg.pins_hi;
    assign o_pins_low_bank_oe  = state_reg.oe_lo;
    assign o_pins_high_bank_oe = state_reg.oe_hi;
    assign o_change            = state_reg.change;

endmodule : ioxr_top

// ===== verif/ioxr_master.sv
`timescale 1ns/1ps
module ioxr_master (
    // clock and resolved data wire
    input  wire logic i_ref_clk,
    input  wire logic i_sda,
    // bus drive, data is open drain
    output logic      o_scl,
    output logic      o_sda_low
);
    // clock stands high and data released outside frames
    initial begin
        o_scl     = 1'b1;
        o_sda_low = 1'b0;
    end
    // data moves with clock low, sampled late in the high phase
    task automatic xfer_bit(input logic b, output logic r);
        o_sda_low <= ~b;
        repeat (2) @(posedge i_ref_clk);
        o_scl <= 1'b1;
        repeat (3) @(posedge i_ref_clk);
        r = i_sda;
        @(posedge i_ref_clk);
        o_scl <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
    endtask : xfer_bit
    // also serves as repeated start from clock low
    task automatic start_cond();
        o_sda_low <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
        o_scl <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        o_sda_low <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        o_scl <= 1'b0;
        repeat (2) @(posedge i_ref_clk);
    endtask : start_cond
    // data rises with clock high, then bus free time
    task automatic stop_cond();
        o_sda_low <= 1'b1;
        repeat (2) @(posedge i_ref_clk);
        o_scl <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        o_sda_low <= 1'b0;
        repeat (8) @(posedge i_ref_clk);
    endtask : stop_cond
    // msb first, line released on the ninth clock for the answer
    task automatic send_byte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(d[i], r);
        end
        xfer_bit(1'b1, r);
        ack = ~r;
    endtask : send_byte
    // last byte is left unacknowledged by holding the line high
    task automatic recv_byte(input logic last, output logic [7:0] d);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xfer_bit(1'b1, r);
            d[i] = r;
        end
        xfer_bit(last, r);
    endtask : recv_byte
endmodule : ioxr_master

// ===== verif/ioxr_sva.sv
`timescale 1ns/1ps
module ioxr_sva (
    // clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_n,
    // serial bus
    input  wire logic       i_scl,
    input  wire logic       i_sda,
    input  wire logic       o_sda,
    input  wire logic       o_sda_oe,
    // port pins
    input  wire logic [7:0] o_pins_low_bank,
    input  wire logic [7:0] o_pins_high_bank,
    input  wire logic [7:0] o_pins_low_bank_oe,
    input  wire logic [7:0] o_pins_high_bank_oe
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_n);

    // pins leave reset as released inputs with the low drive latch all ones
    reset_pins_a : assert property ($rose(i_rst_n) |->
        o_pins_low_bank_oe == 8'h00 && o_pins_high_bank_oe == 8'h00
        && o_pins_low_bank == 8'hff && !o_sda_oe)
        else $error("pins not released after reset");
    // sync latency is a few clocks, so look back past the flops
    ack_take_a : assert property ($rose(o_sda_oe) |->
        !$past(i_scl, 2) && $past(i_scl, 6))
        else $error("data drive taken outside clock low");
    line_release_a : assert property ($fell(o_sda_oe) |->
        !$past(i_scl, 2) && $past(i_scl, 6))
        else $error("data drive released outside clock low");
    data_move_a : assert property (o_sda_oe && $changed(o_sda) |->
        !$past(i_scl, 2) && $past(i_scl, 6))
        else $error("driven data moved outside clock low");
    high_hold_a : assert property ($rose(i_scl) |-> ##1
        ($stable(o_sda_oe) && (!o_sda_oe || $stable(o_sda)))[*6])
        else $error("data line moved while clock high");
    stop_idle_a : assert property ($rose(i_sda) && i_scl && $past(i_scl)
        |-> ##1 (!o_sda_oe)[*8])
        else $error("data driven after stop");
    start_frame_a : assert property ($fell(i_sda) && i_scl && $past(i_scl)
        |-> ##1 (!o_sda_oe)[*8])
        else $error("data driven during address after start");
    pin_update_a : assert property ($changed({o_pins_low_bank,
        o_pins_high_bank, o_pins_low_bank_oe, o_pins_high_bank_oe})
        |-> !$past(i_scl, 2))
        else $error("pins changed away from clock fall");
endmodule : ioxr_sva

bind ioxr_top ioxr_sva u_sva (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n),
    .i_scl(i_scl), .i_sda(i_sda), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
    .o_pins_low_bank(o_pins_low_bank), .o_pins_high_bank(o_pins_high_bank),
    .o_pins_low_bank_oe(o_pins_low_bank_oe),
    .o_pins_high_bank_oe(o_pins_high_bank_oe));

// ===== verif/tb_top.sv
`timescale 1ns/1ps
module tb_top;
    logic       i_ref_clk = 1'b0;
    logic       i_rst_n   = 1'b0;
    logic [2:0] strap     = 3'h0;
    logic [7:0] ext_lo    = 8'hc3;
    logic [7:0] ext_hi    = 8'h5a;
    logic       scl, sda_low, sda_wire, o_sda, o_sda_oe;
    logic [7:0] pins_lo, pins_hi, out_lo, out_hi, oe_lo, oe_hi;
    logic [1:0] change;
    logic [6:0] dev_addr;
    int         mismatches      = 0;
    int         samples_checked = 0;

    always #20 i_ref_clk = ~i_ref_clk;
    // pulled-up wired-and data line; driven pins read back their drive
    assign sda_wire = ~(sda_low | (o_sda_oe & ~o_sda));
    assign pins_lo  = (oe_lo & out_lo) | (~oe_lo & ext_lo);
    assign pins_hi  = (oe_hi & out_hi) | (~oe_hi & ext_hi);
    assign dev_addr = 7'h20 + {4'h0, strap};

    ioxr_master m (.i_ref_clk(i_ref_clk), .i_sda(sda_wire), .o_scl(scl),
        .o_sda_low(sda_low));
    ioxr_top dut (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_scl(scl),
        .i_sda(sda_wire), .o_sda(o_sda), .o_sda_oe(o_sda_oe),
        .i_addr_strap_bit0(strap[0]), .i_addr_strap_bit1(strap[1]),
        .i_addr_strap_bit2(strap[2]), .i_pins_low_bank(pins_lo),
        .i_pins_high_bank(pins_hi), .o_pins_low_bank(out_lo),
        .o_pins_high_bank(out_hi), .o_pins_low_bank_oe(oe_lo),
        .o_pins_high_bank_oe(oe_hi), .o_change(change));

    task automatic check_byte(input string name, input logic [7:0] exp,
                              input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, got);
        end
    endtask : check_byte
    task automatic addr_phase(input logic [6:0] a, input logic rd,
                              input logic exp_ack);
        logic ack;
        m.send_byte({a, rd}, ack);
        check_byte("address ack", {7'h00, exp_ack}, {7'h00, ack});
    endtask : addr_phase
    // command then two data bytes, every byte answered
    task automatic wr_regs(input logic [2:0] cmd, input logic [7:0] d0, d1);
        logic ack;
        m.start_cond();
        addr_phase(dev_addr, 1'b0, 1'b1);
        m.send_byte({5'h00, cmd}, ack);
        check_byte("command ack", 8'h01, {7'h00, ack});
        m.send_byte(d0, ack);
        check_byte("data ack", 8'h01, {7'h00, ack});
        m.send_byte(d1, ack);
        check_byte("data ack", 8'h01, {7'h00, ack});
        m.stop_cond();
    endtask : wr_regs
    task automatic rd2(input logic [2:0] cmd, output logic [7:0] a, b);
        logic ack;
        m.start_cond();
        addr_phase(dev_addr, 1'b0, 1'b1);
        m.send_byte({5'h00, cmd}, ack);
        m.start_cond();
        addr_phase(dev_addr, 1'b1, 1'b1);
        m.recv_byte(1'b0, a);
        m.recv_byte(1'b1, b);
        m.stop_cond();
    endtask : rd2
    // one refused byte, so only the bank read is refreshed
    task automatic rd1(input logic [2:0] cmd, output logic [7:0] a);
        logic ack;
        m.start_cond();
        addr_phase(dev_addr, 1'b0, 1'b1);
        m.send_byte({5'h00, cmd}, ack);
        m.start_cond();
        addr_phase(dev_addr, 1'b1, 1'b1);
        m.recv_byte(1'b1, a);
        m.stop_cond();
    endtask : rd1
    task automatic sc_reset();
        logic [7:0] a, b;
        check_byte("low enables", 8'h00, oe_lo);
        for (int i = 1; i < 4; i++) begin
            rd2(3'(2 * i), a, b);
            check_byte("reset lo", (i == 2) ? 8'h00 : 8'hff, a);
            check_byte("reset hi", (i == 2) ? 8'h00 : 8'hff, b);
        end
    endtask : sc_reset
    // every strap value, a neighbour address and the general call
    task automatic sc_address();
        for (int s = 0; s < 8; s++) begin
            strap <= 3'(s); // straps move only between frames
            repeat (4) @(posedge i_ref_clk);
            m.start_cond();
            addr_phase(7'(32 + s), 1'b0, 1'b1);
            m.stop_cond();
            m.start_cond();
            addr_phase(7'(32 + (s ^ 1)), 1'b0, 1'b0);
            m.stop_cond();
        end
        m.start_cond();
        addr_phase(7'h00, 1'b0, 1'b0);
        m.stop_cond();
    endtask : sc_address
    task automatic sc_write();
        wr_regs(3'h3, 8'ha5, 8'h3c);
        check_byte("high pins", 8'ha5, out_hi);
        check_byte("low pins", 8'h3c, out_lo);
        wr_regs(3'h6, 8'h0f, 8'h00);
        check_byte("low enables", 8'hf0, oe_lo);
        check_byte("high enables", 8'hff, oe_hi);
    endtask : sc_write
    // pointer kept across frames and moved on by each read that ends
    task automatic sc_read();
        logic [7:0] a, b;
        rd2(3'h3, a, b);
        check_byte("first read", 8'ha5, a);
        check_byte("paired read", 8'h3c, b);
        m.start_cond();
        addr_phase(dev_addr, 1'b1, 1'b1);
        m.recv_byte(1'b1, a);
        check_byte("kept pointer", 8'ha5, a);
        m.start_cond();
        addr_phase(dev_addr, 1'b1, 1'b1);
        m.recv_byte(1'b1, a);
        check_byte("restart pointer", 8'h3c, a);
        m.stop_cond();
    endtask : sc_read
    // low bank mixes driven and input pins, levels inverted on report
    task automatic sc_input();
        logic [7:0] a, b;
        wr_regs(3'h4, 8'h55, 8'h00);
        wr_regs(3'h0, 8'h12, 8'h34);
        rd2(3'h0, a, b);
        check_byte("low levels", 8'h66, a);
        check_byte("high levels", 8'ha5, b);
    endtask : sc_input
    // a pin change flags its bank; reading the other bank keeps the flag
    task automatic sc_change();
        logic [7:0] a;
        check_byte("flags idle", 8'h00, {6'h00, change});
        ext_lo <= 8'hc2;
        repeat (4) @(posedge i_ref_clk);
        check_byte("flag raised", 8'h01, {6'h00, change});
        rd1(3'h1, a);
        check_byte("high levels", 8'ha5, a);
        check_byte("flag kept", 8'h01, {6'h00, change});
        rd1(3'h0, a);
        check_byte("low levels", 8'h67, a);
        check_byte("flag cleared", 8'h00, {6'h00, change});
    endtask : sc_change
    task automatic finish_test();
        $display("checked %0d mismatches %0d", samples_checked, mismatches);
        if (mismatches == 0 && samples_checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : finish_test

    // main sequence
    initial begin
        repeat (5) @(posedge i_ref_clk);
        i_rst_n <= 1'b1;
        repeat (4) @(posedge i_ref_clk);
        sc_reset();
        sc_address();
        sc_write();
        sc_read();
        sc_input();
        sc_change();
        finish_test();
    end
    // a hang counts as a mismatch
    initial begin
        repeat (100000) @(posedge i_ref_clk);
        mismatches++;
        finish_test();
    end
endmodule : tb_top
